// ==== common/supply_diag_defs.svh ====
`ifndef SUPPLY_DIAG_DEFS_SVH
`define SUPPLY_DIAG_DEFS_SVH
// Behaviour
// - Detectors run continuously in active or sleep
// - Detector failure sets flag or causes reset
// - Overvoltage, undervoltage, oscillation set own flags
// - Digital undervoltage resets, records no flag
// - Analog undervoltage resets, then flags cause
// - Thermistor failure flags and saturates temperature faults
// - Open return or ground sets open flag
// - Analog/thermistor oscillation may accompany over/under
// - Self-test covers listed supply flag paths
// - Host writes start bit to begin test
// - Force each path's comparator to fail
// - Check register trigger and pin trigger
// - Clear fault registers, release pin trigger
// - Repeat force, check, clear per path
// - Run completes always; report fail flag
// - No-clear option skips the clear step
// - Thermistor disabled at start: ignore its results
// - Fault pin toggles; host ignores or disables

// Detector index (one bit per detection path)
`define DET_AOV        4'd0
`define DET_AOSC       4'd1
`define DET_DOV        4'd2
`define DET_COV        4'd3
`define DET_CUV        4'd4
`define DET_HOPEN      4'd5
`define DET_DOPEN      4'd6
`define DET_COPEN      4'd7
`define DET_TOV        4'd8
`define DET_TUV        4'd9
`define DET_TOSC       4'd10
`define DET_NUV        4'd11
`define DET_HOSC       4'd12
`define DET_COUNT      13
`define THERM_MASK     13'h0700

// Register one field positions
`define R1_AOV         0
`define R1_AOSC        1
`define R1_AUV_RST     2
`define R1_DOV         3
`define R1_COV         4
`define R1_CUV         5
`define R1_HOPEN       6
`define R1_DOPEN       7
`define R1_COPEN       8
// Register two field positions
`define R2_TOV         0
`define R2_TUV         1
`define R2_TOSC        2
`define R2_NUV         3
`define R2_HOSC        4
`define R2_FAIL        5

`define FAULT_RST      8'h00
`define TEMP_ALL_ONES  8'hFF
// Wait for trigger before declaring path failed
`define CHECK_TIME_NS  50
`define CLK_PERIOD_NS  5
`define CHECK_CYCLES   (`CHECK_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== common/supply_diag_pkg.sv ====
package supply_diag_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_FORCE, ST_CHECK, ST_CLEAR, ST_NEXT
	} bist_state_e;

	typedef struct packed {
		logic start;
		logic no_clear;
		logic therm_enabled;
		logic fault_pin_enable;
	} diag_ctrl_s;
endpackage : supply_diag_pkg

// ==== hw/supply_diag_bist_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "supply_diag_defs.svh"
module supply_diag_bist_engine #(
	parameter int N_DET    = `DET_COUNT,
	parameter int TEMP_W   = 8,
	parameter int CHECK_CY = `CHECK_CYCLES
) (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	// Mode and control
	input  wire logic                      mode_active_or_sleep,
	input  wire supply_diag_pkg::diag_ctrl_s ctrl,
	input  wire logic                      clear_faults,
	input  wire logic                      digital_supply_uv,
	input  wire logic                      analog_supply_uv,
	// Comparator outputs (asynchronous)
	input  wire logic [N_DET-1:0]          det_raw,
	// Comparator force
	output logic      [N_DET-1:0]          det_force,
	// Status
	output logic      [8:0]                supply_fault_reg_one,
	output logic      [5:0]                supply_fault_reg_two,
	output logic      [TEMP_W-1:0]         overtemp_fault_reg,
	output logic      [TEMP_W-1:0]         undertemp_fault_reg,
	output logic                           selftest_busy,
	output logic                           digital_reset_req,
	output logic                           fault_output_pin_n,
	output logic                           fault_pin_oe_n
);
	if (N_DET != `DET_COUNT || CHECK_CY < 1 || CHECK_CY > 65535
		|| TEMP_W < 1) begin : g_bad_param
		$error("supply_diag_bist_engine: bad parameters");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [N_DET-1:0] s1_reg, s2_reg, s3_reg, det_reg;
	logic [1:0]       u1_reg, u2_reg, u3_reg, uv_reg;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			det_reg <= '0;
			u1_reg  <= 2'h0;
			u2_reg  <= 2'h0;
			u3_reg  <= 2'h0;
			uv_reg  <= 2'h0;
		end else begin
			s1_reg <= det_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < N_DET; i++)
				if (s2_reg[i] == s3_reg[i])
					det_reg[i] <= s2_reg[i];
			u1_reg <= {analog_supply_uv, digital_supply_uv};
			u2_reg <= u1_reg;
			u3_reg <= u2_reg;
			for (int j = 0; j < 2; j++)
				if (u2_reg[j] == u3_reg[j])
					uv_reg[j] <= u2_reg[j];
		end
	end

	// ----------------------------------------
	// Self-test sequencer
	// ----------------------------------------
	supply_diag_pkg::bist_state_e state_reg;
	logic [3:0]  path_reg;
	logic [15:0] wait_reg;
	logic        fail_reg;
	logic        therm_ok_reg;
	logic        start_q_reg;
	logic        bist_clear;
	logic        path_seen;
	logic        path_skip;
	logic        trig_any;
	logic [N_DET-1:0] therm_mask;

	// Fault triggers: register set and pin assert
	logic [N_DET-1:0] set_trig;
	logic             pin_trig;
	assign set_trig = mode_active_or_sleep ? det_reg : '0;
	assign path_seen = set_trig[path_reg] && pin_trig;
	assign therm_mask = N_DET'(`THERM_MASK);
	assign path_skip = !therm_ok_reg && therm_mask[path_reg];
	assign bist_clear = (state_reg == supply_diag_pkg::ST_CLEAR)
		&& !ctrl.no_clear;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg    <= supply_diag_pkg::ST_IDLE;
			path_reg     <= 4'h0;
			wait_reg     <= 16'h0000;
			fail_reg     <= 1'b0;
			therm_ok_reg <= 1'b0;
			start_q_reg  <= 1'b0;
			det_force    <= '0;
		end else begin
			start_q_reg <= ctrl.start;
			case (state_reg)
			supply_diag_pkg::ST_IDLE: begin
				det_force <= '0;
				if (ctrl.start && !start_q_reg) begin
					state_reg    <= supply_diag_pkg::ST_FORCE;
					path_reg     <= 4'h0;
					fail_reg     <= 1'b0;
					therm_ok_reg <= ctrl.therm_enabled;
				end
			end
			supply_diag_pkg::ST_FORCE: begin
				det_force           <= '0;
				det_force[path_reg] <= 1'b1;
				wait_reg            <= 16'h0000;
				state_reg           <= supply_diag_pkg::ST_CHECK;
			end
			supply_diag_pkg::ST_CHECK: begin
				wait_reg <= wait_reg + 16'h0001;
				if (path_seen || wait_reg >= 16'(CHECK_CY)) begin
					if (!path_seen && !path_skip)
						fail_reg <= 1'b1;
					det_force <= '0;
					wait_reg  <= 16'h0000;
					state_reg <= supply_diag_pkg::ST_CLEAR;
				end
			end
			// Hold the clear until the released detector has settled
			supply_diag_pkg::ST_CLEAR: begin
				wait_reg <= wait_reg + 16'h0001;
				if (!trig_any || wait_reg >= 16'(CHECK_CY))
					state_reg <= supply_diag_pkg::ST_NEXT;
			end
			supply_diag_pkg::ST_NEXT: begin
				if (path_reg == 4'(N_DET - 1))
					state_reg <= supply_diag_pkg::ST_IDLE;
				else begin
					path_reg  <= path_reg + 4'h1;
					state_reg <= supply_diag_pkg::ST_FORCE;
				end
			end
			default:
				state_reg <= supply_diag_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			selftest_busy <= 1'b0;
		else
			selftest_busy <= state_reg != supply_diag_pkg::ST_IDLE
				|| (ctrl.start && !start_q_reg);
	end

	// ----------------------------------------
	// Fault registers
	// ----------------------------------------
	logic [8:0] r1_set;
	logic [5:0] r2_set;
	logic       therm_fault;
	logic       aov_rst_reg;
	always_comb begin
		r1_set = 9'h000;
		r2_set = 6'h00;
		r1_set[`R1_AOV]   = set_trig[`DET_AOV];
		r1_set[`R1_AOSC]  = set_trig[`DET_AOSC];
		r1_set[`R1_DOV]   = set_trig[`DET_DOV];
		r1_set[`R1_COV]   = set_trig[`DET_COV];
		r1_set[`R1_CUV]   = set_trig[`DET_CUV];
		r1_set[`R1_HOPEN] = set_trig[`DET_HOPEN];
		r1_set[`R1_DOPEN] = set_trig[`DET_DOPEN];
		r1_set[`R1_COPEN] = set_trig[`DET_COPEN];
		r2_set[`R2_TOV]   = set_trig[`DET_TOV];
		r2_set[`R2_TUV]   = set_trig[`DET_TUV];
		r2_set[`R2_TOSC]  = set_trig[`DET_TOSC];
		r2_set[`R2_NUV]   = set_trig[`DET_NUV];
		r2_set[`R2_HOSC]  = set_trig[`DET_HOSC];
	end
	assign therm_fault = |(set_trig & N_DET'(`THERM_MASK));
	assign pin_trig = fault_output_pin_n == 1'b0;
	assign trig_any = (|r1_set) || (|r2_set);

	// Sticky flags: set wins over clear
	logic       auv_cause_set;
	logic       fail_done;
	logic [8:0] r1_keep;
	logic [8:0] r1_cause;
	assign auv_cause_set = aov_rst_reg && !uv_reg[1];
	assign fail_done = state_reg == supply_diag_pkg::ST_NEXT
		&& path_reg == 4'(N_DET - 1);
	always_comb begin
		r1_keep = {9{!clear_faults && !bist_clear}};
		r1_keep[`R1_AUV_RST] = !clear_faults;
		r1_cause = 9'h000;
		r1_cause[`R1_AUV_RST] = auv_cause_set;
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			supply_fault_reg_one <= 9'h000;
		else
			supply_fault_reg_one <= r1_set | r1_cause
				| (supply_fault_reg_one & r1_keep);
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			supply_fault_reg_two <= 6'h00;
		end else begin
			supply_fault_reg_two[4:0] <= r2_set[4:0]
				| (supply_fault_reg_two[4:0]
				& {5{!clear_faults && !bist_clear}});
			if (fail_done)
				supply_fault_reg_two[`R2_FAIL] <= fail_reg;
			else if (clear_faults && !selftest_busy)
				supply_fault_reg_two[`R2_FAIL] <= 1'b0;
		end
	end

	// Reset cause survives the digital reset it requested
	always_ff @(posedge clock) begin
		if (!rst_n)
			aov_rst_reg <= 1'b0;
		else
			aov_rst_reg <= uv_reg[1];
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			digital_reset_req <= 1'b0;
		else
			digital_reset_req <= |uv_reg;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			overtemp_fault_reg  <= '0;
			undertemp_fault_reg <= '0;
		end else if (therm_fault) begin
			overtemp_fault_reg  <= '1;
			undertemp_fault_reg <= '1;
		end else if (clear_faults || bist_clear) begin
			overtemp_fault_reg  <= '0;
			undertemp_fault_reg <= '0;
		end
	end

	// ----------------------------------------
	// Fault pin
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fault_output_pin_n <= 1'b1;
			fault_pin_oe_n     <= 1'b1;
		end else begin
			fault_output_pin_n <= !((|r1_set) || (|r2_set)
				|| (!fault_output_pin_n && !clear_faults
				&& !bist_clear));
			fault_pin_oe_n <= !ctrl.fault_pin_enable;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_force_one_hot: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == supply_diag_pkg::ST_CHECK |-> $onehot(det_force))
		else $error("force not one-hot");
	a_start_runs: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == supply_diag_pkg::ST_IDLE && ctrl.start && !start_q_reg
		|=> state_reg == supply_diag_pkg::ST_FORCE)
		else $error("start ignored");
	a_therm_ones: assert property (@(posedge clock) disable iff (!rst_n)
		therm_fault |=> overtemp_fault_reg == '1 && undertemp_fault_reg == '1)
		else $error("temp not saturated");
	a_clear_step: assert property (@(posedge clock) disable iff (!rst_n)
		bist_clear && !(|r1_set) && !(|r2_set)
		|=> supply_fault_reg_one[8:3] == 6'h00
		&& supply_fault_reg_one[1:0] == 2'h0
		&& supply_fault_reg_two[4:0] == 5'h00 && fault_output_pin_n)
		else $error("clear step failed");
	a_no_clear: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl.no_clear && !clear_faults && supply_fault_reg_one[`R1_AOV]
		|=> supply_fault_reg_one[`R1_AOV])
		else $error("flag lost");
	a_dig_uv: assert property (@(posedge clock) disable iff (!rst_n)
		uv_reg[0] |=> digital_reset_req)
		else $error("no digital reset");
	a_path_step: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == supply_diag_pkg::ST_NEXT && path_reg != 4'(N_DET - 1)
		|=> path_reg == $past(path_reg) + 4'h1)
		else $error("path not advanced");
	a_check_bound: assert property (@(posedge clock) disable iff (!rst_n)
		state_reg == supply_diag_pkg::ST_FORCE
		|=> ##[1:20] state_reg == supply_diag_pkg::ST_CLEAR)
		else $error("check hung");
	a_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
		set_trig[`DET_CUV] |=> supply_fault_reg_one[`R1_CUV])
		else $error("flag not set");
endmodule : supply_diag_bist_engine
`default_nettype wire

// ==== tb/supply_diag_bist_engine_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "supply_diag_defs.svh"
module supply_diag_bist_engine_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                        clock;
	logic                        rst_n;
	logic                        mode;
	logic                        clr;
	logic                        duv;
	logic                        auv;
	logic                        loop_en;
	supply_diag_pkg::diag_ctrl_s ctrl;
	logic [12:0]                 manual;
	logic [12:0]                 broken;
	logic [12:0]                 force_v;
	logic [12:0]                 last_f;
	wire logic [12:0]            raw;
	logic [8:0]                  r1;
	logic [5:0]                  r2;
	logic [7:0]                  ot;
	logic [7:0]                  ut;
	logic                        busy;
	logic                        rst_req;
	logic                        pin_n;
	logic                        oe_n;
	int                          num_errors;
	int                          n_compared;
	int                          next_idx;
	int                          pin_lows;

	// Comparators echo the force unless a path is broken
	assign raw = loop_en ? (force_v & ~broken) : manual;

	supply_diag_bist_engine dut (
		.clock                (clock),
		.rst_n                (rst_n),
		.mode_active_or_sleep (mode),
		.ctrl                 (ctrl),
		.clear_faults         (clr),
		.digital_supply_uv    (duv),
		.analog_supply_uv     (auv),
		.det_raw              (raw),
		.det_force            (force_v),
		.supply_fault_reg_one (r1),
		.supply_fault_reg_two (r2),
		.overtemp_fault_reg   (ot),
		.undertemp_fault_reg  (ut),
		.selftest_busy        (busy),
		.digital_reset_req    (rst_req),
		.fault_output_pin_n   (pin_n),
		.fault_pin_oe_n       (oe_n)
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task summarize;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc

	task clear_all;
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		cyc(1);
	endtask : clear_all

	task run_bist(input logic nc, input logic th, input logic [12:0] brk);
		int k;
		broken = brk;
		ctrl.no_clear = nc;
		ctrl.therm_enabled = th;
		loop_en = 1'b1;
		next_idx = 0;
		pin_lows = 0;
		chk(16'({r1, r2}), 16'h0000, "no faults before run");
		ctrl.start = 1'b1;
		cyc(1);
		ctrl.start = 1'b0;
		cyc(1);
		chk(16'(busy), 16'h1, "run started");
		k = 0;
		while (busy !== 1'b0 && k < 1000) begin
			cyc(1);
			k++;
		end
		chk(16'(k < 1000), 16'h1, "run finished");
		chk(16'(next_idx), 16'(`DET_COUNT), "paths visited");
		loop_en = 1'b0;
	endtask : run_bist

	// ----------------------------------------
	// Run monitor: path order and pin activity
	// ----------------------------------------
	always @(negedge clock) begin
		last_f <= force_v;
		if (busy === 1'b1) begin
			if (pin_n === 1'b0) pin_lows++;
			if (force_v !== 13'h0000 && force_v !== last_f) begin
				chk(16'(force_v), 16'(13'h1 << next_idx), "force order");
				next_idx++;
			end
		end
	end

	initial begin
		#100000;
		num_errors++;
		summarize();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0; mode = 1'b1; clr = 1'b0; duv = 1'b0; auv = 1'b0;
		loop_en = 1'b0; ctrl = '0; manual = '0; broken = '0; last_f = '0;
		num_errors = 0; n_compared = 0; next_idx = 0; pin_lows = 0;
		cyc(2);
		rst_n = 1'b1;
		cyc(1);
		chk(16'({r1, r2}), 16'h0000, "flags after reset");
		chk(16'({pin_n, oe_n, busy}), 16'h0006, "pins after reset");
		ctrl.therm_enabled = 1'b1;
		for (int i = 0; i < `DET_COUNT; i++) begin
			manual = 13'h1 << i;
			cyc(6);
			manual = '0;
			cyc(5);
			if (i < 8) chk(16'(r1[i < 2 ? i : i + 1]), 16'h1, "flag one");
			else chk(16'(r2[i - 8]), 16'h1, "flag two");
			if (i >= 8 && i <= 10) chk({ot, ut}, 16'hFFFF, "temp all ones");
			clear_all();
			chk(16'({r1, r2, pin_n}), 16'h0001, "flags cleared");
		end
		// Inactive mode records nothing
		mode = 1'b0;
		manual = 13'h0004;
		cyc(6);
		chk(16'(r1), 16'h0000, "inactive mode");
		manual = '0;
		cyc(5);
		mode = 1'b1;
		duv = 1'b1;
		cyc(6);
		chk(16'(rst_req), 16'h1, "digital uv reset");
		duv = 1'b0;
		cyc(6);
		chk(16'({r1, r2}), 16'h0000, "digital uv no flag");
		auv = 1'b1;
		cyc(6);
		chk(16'(rst_req), 16'h1, "analog uv reset");
		auv = 1'b0;
		cyc(6);
		chk(16'(r1[`R1_AUV_RST]), 16'h1, "analog uv cause");
		clear_all();
		ctrl.fault_pin_enable = 1'b1;
		cyc(2);
		chk(16'(oe_n), 16'h0, "pin driven");
		// Self-test runs
		run_bist(1'b0, 1'b1, 13'h0000);
		chk(16'({r1, r2, pin_n}), 16'h0001, "clean pass");
		chk(16'(pin_lows > 0), 16'h1, "pin toggled");
		run_bist(1'b1, 1'b1, 13'h0008);
		chk(16'(r1), 16'h01EB, "no clear one");
		chk(16'(r2), 16'h003F, "no clear two");
		chk({ot, ut}, 16'hFFFF, "temp kept");
		clear_all();
		run_bist(1'b0, 1'b1, 13'h1000);
		chk(16'({r1, r2}), 16'h0020, "fail reported");
		clear_all();
		run_bist(1'b0, 1'b0, 13'h0200);
		chk(16'(r2), 16'h0000, "therm ignored");
		summarize();
	end
endmodule : supply_diag_bist_engine_test
`default_nettype wire
